// ===== hw/timer_pkg.sv
// Functional notes
// - Timer function advances the count once per machine cycle of six oscillator periods.
// - Counter function samples the count pin once per machine cycle, counting falls.
// - Increment only when one sample is high and the next sample is low.
// - The new count appears in the machine cycle after the detecting one.
// - A fall needs two machine cycles, so events count at most at clock/12.
// - Source-select bit clear counts machine cycles; set counts the count pin.
// - Gate bit set: count only while gate pin high and run bit set.
// - Gate bit clear: count whenever the run bit is set.
// - Two-bit mode field selects four modes; mode 3 differs per timer.
// - Mode register: timer 1 fields in bits 7..4, timer 0 in bits 3..0.
// - Mode register resets to zero and is written only as a whole byte.
// - Run bits start and stop counting; overflow flags set by rollover, cleared by interrupt acknowledge or a control write.
// - Mode 0 is a 13-bit count, mode 1 a 16-bit count, both flagging rollover.
// - Mode 2 counts the low byte and reloads it from the high byte.
// - Mode 3: timer 1 holds; timer 0 splits, high half uses timer 1 controls.
`default_nettype none
package timer_pkg;
	localparam int unsigned MCYCLE_OSC = 6;
	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_CONTROL = 8'h88;
	localparam logic [7:0] IDX_MODE = 8'h89;
	localparam logic [7:0] IDX_LOW0 = 8'h90;
	localparam logic [7:0] IDX_LOW1 = 8'h91;
	localparam logic [7:0] IDX_HIGH0 = 8'h92;
	localparam logic [7:0] IDX_HIGH1 = 8'h93;
	localparam logic [7:0] IDX_STATUS = 8'h94;
	localparam logic [7:0] IDX_MASK = 8'h95;
	// Mode register fields
	localparam int unsigned T1_FIELD = 4;
	localparam int unsigned T0_FIELD = 0;
	localparam int unsigned GATE_BIT = 3;
	localparam int unsigned SRC_BIT = 2;
	// Control register fields
	localparam int unsigned TF1_BIT = 7;
	localparam int unsigned TR1_BIT = 6;
	localparam int unsigned TF0_BIT = 5;
	localparam int unsigned TR0_BIT = 4;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [1:0] MASK_RESET = 2'h0;
	typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD, MODE_SPLIT} count_mode_t;
endpackage
`default_nettype wire

// ===== hw/machine_cycle_gen.sv
`default_nettype none
module machine_cycle_gen #(
	parameter int unsigned PERIOD = timer_pkg::MCYCLE_OSC
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	output logic tick
);
	localparam int unsigned CW = $clog2(PERIOD);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic tick;
	} mc_state_t;
	mc_state_t st_ff;
	mc_state_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (st_ff.cnt == CW'(PERIOD - 1)) begin
			nxt_st.cnt = '0;
			nxt_st.tick = 1'b1;
		end else begin
			nxt_st.cnt = st_ff.cnt + CW'(1);
			nxt_st.tick = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tick = st_ff.tick;

	property p_tick_period;
		@(posedge ref_clk) disable iff (!rst_b) tick |=> !tick [*5] ##1 tick;
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("machine cycle not six clocks");
endmodule
`default_nettype wire

// ===== hw/pin_sampler.sv
`default_nettype none
module pin_sampler (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic tick,
	input wire logic pinIn,
	output logic level,
	output logic fall
);
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic samp;
		logic prev;
	} ps_state_t;
	ps_state_t st_ff;
	ps_state_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.sync1 = pinIn;
		nxt_st.sync2 = st_ff.sync1;
		if (tick) begin
			nxt_st.samp = st_ff.sync2;
			nxt_st.prev = st_ff.samp;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign level = st_ff.samp;
	// Held for a whole machine cycle, so the counter consumes it at the next tick
	assign fall = st_ff.prev & ~st_ff.samp;

	property p_fall_one_mcycle;
		@(posedge ref_clk) disable iff (!rst_b) $rose(fall) |-> fall [*6] ##1 !fall;
	endproperty
	a_fall_one_mcycle: assert property (p_fall_one_mcycle) else $error("fall not one machine cycle");
endmodule
`default_nettype wire

// ===== hw/dual_timer_counter.sv
`default_nettype none
module dual_timer_counter #(
	parameter int unsigned MCYCLE_OSC = timer_pkg::MCYCLE_OSC
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic countPinZero,
	input wire logic countPinOne,
	input wire logic externalGatePin0,
	input wire logic externalGatePin1,
	input wire logic intAck0,
	input wire logic intAck1,
	output logic irq
);
	typedef struct packed {
		logic [7:0] modeReg;
		logic run0;
		logic run1;
		logic ovf0;
		logic ovf1;
		logic [7:0] low0;
		logic [7:0] high0;
		logic [7:0] low1;
		logic [7:0] high1;
		logic [1:0] status;
		logic [1:0] mask;
		logic irq;
		logic dWrite;
		logic rdWait;
		logic dMapped;
		logic [7:0] dIdx;
		logic [31:0] rdata;
	} tc_state_t;
	tc_state_t st_ff;
	tc_state_t nxt_st;

	logic tick;
	logic [3:0] pins;
	logic [3:0] lvl;
	logic [3:0] fal;
	timer_pkg::count_mode_t mode0;
	timer_pkg::count_mode_t mode1;
	logic gate0, gate1, src0, src1;
	logic inc0, inc1, incHi0;
	logic set0, set1;
	logic [16:0] step0, step1;
	logic [8:0] splitLo, splitHi;
	logic [15:0] cnt0, cnt1;
	logic accept, ctlWr, rdClr;
	logic [7:0] wd;
	logic [7:0] readVal;

	// One ALU for modes 0..2; result is {overflow, high, low}
	function automatic logic [16:0] countStep(input timer_pkg::count_mode_t m,
		input logic [7:0] lo, input logic [7:0] hi);
		logic [5:0] p;
		logic [8:0] h;
		logic [8:0] l;
		logic [16:0] r;
		p = {1'b0, lo[4:0]} + 6'h01;
		h = {1'b0, hi} + {8'h00, p[5]};
		l = {1'b0, lo} + 9'h001;
		r = {1'b0, hi, lo};
		unique case (m)
			timer_pkg::MODE_13BIT: begin
				// Upper three low-byte bits are left alone
				r = {h[8], h[7:0], lo[7:5], p[4:0]};
			end
			timer_pkg::MODE_16BIT: begin
				r = {1'b0, hi, lo} + 17'h00001;
			end
			timer_pkg::MODE_RELOAD: begin
				r = l[8] ? {1'b1, hi, hi} : {1'b0, hi, l[7:0]};
			end
			timer_pkg::MODE_SPLIT: begin
				r = {1'b0, hi, lo};
			end
		endcase
		return r;
	endfunction

	machine_cycle_gen #(
		.PERIOD(MCYCLE_OSC)
	) u_mcycle (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.tick(tick)
	);

	assign pins = {externalGatePin1, externalGatePin0, countPinOne, countPinZero};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin
			pin_sampler u_samp (
				.ref_clk(ref_clk),
				.rst_b(rst_b),
				.tick(tick),
				.pinIn(pins[gi]),
				.level(lvl[gi]),
				.fall(fal[gi])
			);
		end
	endgenerate

	assign mode0 = timer_pkg::count_mode_t'(st_ff.modeReg[timer_pkg::T0_FIELD +: 2]);
	assign mode1 = timer_pkg::count_mode_t'(st_ff.modeReg[timer_pkg::T1_FIELD +: 2]);
	assign gate0 = st_ff.modeReg[timer_pkg::T0_FIELD + timer_pkg::GATE_BIT];
	assign gate1 = st_ff.modeReg[timer_pkg::T1_FIELD + timer_pkg::GATE_BIT];
	assign src0 = st_ff.modeReg[timer_pkg::T0_FIELD + timer_pkg::SRC_BIT];
	assign src1 = st_ff.modeReg[timer_pkg::T1_FIELD + timer_pkg::SRC_BIT];

	// Pin falls were found at the previous tick, so the count moves one machine cycle later
	assign inc0 = tick & st_ff.run0 & (~gate0 | lvl[2]) & (src0 ? fal[0] : 1'b1);
	assign inc1 = tick & st_ff.run1 & (~gate1 | lvl[3]) & (src1 ? fal[1] : 1'b1)
		& (mode1 != timer_pkg::MODE_SPLIT);
	assign incHi0 = tick & st_ff.run1 & (mode0 == timer_pkg::MODE_SPLIT);

	assign step0 = countStep(mode0, st_ff.low0, st_ff.high0);
	assign step1 = countStep(mode1, st_ff.low1, st_ff.high1);
	assign splitLo = {1'b0, st_ff.low0} + 9'h001;
	assign splitHi = {1'b0, st_ff.high0} + 9'h001;
	assign set0 = inc0 & ((mode0 == timer_pkg::MODE_SPLIT) ? splitLo[8] : step0[16]);
	// A split timer 0 takes over the timer 1 flag
	assign set1 = (mode0 == timer_pkg::MODE_SPLIT) ? (incHi0 & splitHi[8]) : (inc1 & step1[16]);
	assign cnt0 = {st_ff.high0, st_ff.low0};
	assign cnt1 = {st_ff.high1, st_ff.low1};

	assign accept = hsel & htrans[1] & hready;
	assign wd = hwdata[7:0];
	assign ctlWr = st_ff.dWrite & st_ff.dMapped & (st_ff.dIdx == timer_pkg::IDX_CONTROL);
	assign rdClr = st_ff.rdWait & st_ff.dMapped & (st_ff.dIdx == timer_pkg::IDX_STATUS);

	always_comb begin
		readVal = 8'h00;
		case (st_ff.dIdx)
			timer_pkg::IDX_CONTROL: begin
				readVal[timer_pkg::TF1_BIT] = st_ff.ovf1;
				readVal[timer_pkg::TR1_BIT] = st_ff.run1;
				readVal[timer_pkg::TF0_BIT] = st_ff.ovf0;
				readVal[timer_pkg::TR0_BIT] = st_ff.run0;
			end
			timer_pkg::IDX_MODE: readVal = st_ff.modeReg;
			timer_pkg::IDX_LOW0: readVal = st_ff.low0;
			timer_pkg::IDX_LOW1: readVal = st_ff.low1;
			timer_pkg::IDX_HIGH0: readVal = st_ff.high0;
			timer_pkg::IDX_HIGH1: readVal = st_ff.high1;
			timer_pkg::IDX_STATUS: readVal = {6'h00, st_ff.status};
			timer_pkg::IDX_MASK: readVal = {6'h00, st_ff.mask};
			default: readVal = 8'h00;
		endcase
	end

	always_comb begin
		nxt_st = st_ff;
		if (inc0) begin
			if (mode0 == timer_pkg::MODE_SPLIT) begin
				nxt_st.low0 = splitLo[7:0];
			end else begin
				{nxt_st.high0, nxt_st.low0} = step0[15:0];
			end
		end
		if (incHi0) begin
			nxt_st.high0 = splitHi[7:0];
		end
		if (inc1) begin
			{nxt_st.high1, nxt_st.low1} = step1[15:0];
		end
		// A software write to a count byte wins over a count in the same cycle
		if (st_ff.dWrite && st_ff.dMapped) begin
			case (st_ff.dIdx)
				timer_pkg::IDX_MODE: nxt_st.modeReg = wd;
				timer_pkg::IDX_CONTROL: begin
					nxt_st.run1 = wd[timer_pkg::TR1_BIT];
					nxt_st.run0 = wd[timer_pkg::TR0_BIT];
				end
				timer_pkg::IDX_LOW0: nxt_st.low0 = wd;
				timer_pkg::IDX_LOW1: nxt_st.low1 = wd;
				timer_pkg::IDX_HIGH0: nxt_st.high0 = wd;
				timer_pkg::IDX_HIGH1: nxt_st.high1 = wd;
				timer_pkg::IDX_MASK: nxt_st.mask = wd[1:0];
				default: nxt_st.mask = st_ff.mask;
			endcase
		end
		// Rollover sets win over any clear in the same cycle
		nxt_st.ovf0 = (ctlWr ? wd[timer_pkg::TF0_BIT] : (st_ff.ovf0 & ~intAck0)) | set0;
		nxt_st.ovf1 = (ctlWr ? wd[timer_pkg::TF1_BIT] : (st_ff.ovf1 & ~intAck1)) | set1;
		nxt_st.status = (rdClr ? 2'b00 : st_ff.status) | {set1, set0};
		nxt_st.irq = |(nxt_st.status & nxt_st.mask);
		// Reads take one wait state so a write just before is already visible
		if (st_ff.rdWait) begin
			nxt_st.rdata = st_ff.dMapped ? {24'h000000, readVal} : 32'h00000000;
		end
		nxt_st.dWrite = accept & hwrite;
		nxt_st.rdWait = accept & ~hwrite;
		if (accept) begin
			nxt_st.dIdx = haddr[9:2];
			nxt_st.dMapped = (haddr[31:10] == 22'h000000);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign hreadyout = ~st_ff.rdWait;
	assign hresp = 1'b0;
	assign hrdata = st_ff.rdata;
	assign irq = st_ff.irq;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_t0_free_timer;
		tick && mode0 == timer_pkg::MODE_16BIT && !src0 && !gate0 && st_ff.run0 && !st_ff.dWrite;
	endsequence
	sequence s_t0_event_fall;
		tick && fal[0] && mode0 == timer_pkg::MODE_16BIT && src0 && !gate0 && st_ff.run0
			&& !st_ff.dWrite;
	endsequence

	property p_timer_rate;
		s_t0_free_timer |=> cnt0 == $past(cnt0) + 16'h0001;
	endproperty
	a_timer_rate: assert property (p_timer_rate) else $error("timer did not count machine cycle");

	property p_event_next_mcycle;
		s_t0_event_fall |=> cnt0 == $past(cnt0) + 16'h0001;
	endproperty
	a_event_next_mcycle: assert property (p_event_next_mcycle) else $error("fall not counted");

	property p_event_needs_fall;
		src0 && !fal[0] && mode0 == timer_pkg::MODE_16BIT && !st_ff.dWrite |=> $stable(cnt0);
	endproperty
	a_event_needs_fall: assert property (p_event_needs_fall) else $error("count without fall");

	property p_gate_blocks;
		gate0 && !lvl[2] && mode0 != timer_pkg::MODE_SPLIT && !st_ff.dWrite |=> $stable(cnt0);
	endproperty
	a_gate_blocks: assert property (p_gate_blocks) else $error("gated timer counted");

	property p_mode0_carry;
		inc0 && mode0 == timer_pkg::MODE_13BIT && st_ff.low0[4:0] == 5'h1f && !st_ff.dWrite
			|=> st_ff.low0[4:0] == 5'h00 && st_ff.high0 == $past(st_ff.high0) + 8'h01;
	endproperty
	a_mode0_carry: assert property (p_mode0_carry) else $error("13-bit carry wrong");

	property p_reload;
		inc0 && mode0 == timer_pkg::MODE_RELOAD && st_ff.low0 == 8'hff && !st_ff.dWrite
			|=> st_ff.low0 == $past(st_ff.high0) && st_ff.ovf0 && st_ff.status[0];
	endproperty
	a_reload: assert property (p_reload) else $error("reload or flag missing");

	property p_t1_split_hold;
		mode1 == timer_pkg::MODE_SPLIT && !st_ff.dWrite |=> $stable(cnt1);
	endproperty
	a_t1_split_hold: assert property (p_t1_split_hold) else $error("timer 1 moved in mode 3");

	property p_split_high;
		tick && st_ff.run1 && mode0 == timer_pkg::MODE_SPLIT && st_ff.high0 == 8'hff
			&& !st_ff.dWrite |=> st_ff.high0 == 8'h00 && st_ff.ovf1 && (irq || !st_ff.mask[1]);
	endproperty
	a_split_high: assert property (p_split_high) else $error("split high half wrong");

	property p_mode_write;
		st_ff.dWrite && st_ff.dMapped && st_ff.dIdx == timer_pkg::IDX_MODE
			|=> st_ff.modeReg == $past(hwdata[7:0]);
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("mode register not written");
endmodule
`default_nettype wire

// ===== verification/count_source.sv
`default_nettype none
module count_source (
	input wire logic ref_clk,
	output logic countPin,
	output logic gatePin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		countPin = 1'b0;
		gatePin = 1'b0;
	end
	task automatic setGate(input logic g);
		gatePin <= g;
	endtask
	// Whole machine cycles per level, so no level slips between two samples
	task automatic pulses(input int n, input int mc);
		repeat (n) begin
			countPin <= 1'b1;
			repeat (mc * (1 + $urandom_range(2))) @(posedge ref_clk);
			countPin <= 1'b0;
			repeat (mc * (1 + $urandom_range(2))) @(posedge ref_clk);
		end
	endtask
endmodule
`default_nettype wire

// ===== verification/dual_timer_counter_front_end_tb_top.sv
`default_nettype none
module dual_timer_counter_front_end_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MC = 6;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] intAck = 2'h0;
	logic hreadyout, hresp, irq, rdySeen;
	logic [31:0] hrdata, rdSeen;
	logic [7:0] v;
	wire logic cnt0, cnt1, gate0, gate1;
	int cyc = 0;
	int fail_count = 0;
	int checks = 0;

	always #20 ref_clk = ~ref_clk;
	// Copies taken at the edge avoid racing the slave's own updates
	always @(posedge ref_clk) begin
		rdySeen <= hreadyout;
		rdSeen <= hrdata;
		cyc <= cyc + 1;
	end

	dual_timer_counter #(.MCYCLE_OSC(MC)) u_dual_timer_counter (
		.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .countPinZero(cnt0),
		.countPinOne(cnt1), .externalGatePin0(gate0), .externalGatePin1(gate1),
		.intAck0(intAck[0]), .intAck1(intAck[1]), .irq(irq)
	);
	count_source u_src0 (.ref_clk(ref_clk), .countPin(cnt0), .gatePin(gate0));
	count_source u_src1 (.ref_clk(ref_clk), .countPin(cnt1), .gatePin(gate1));

	function automatic logic [9:0] ad(input int i);
		return 10'(i * 4);
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic waitReady(inout int n);
		do begin
			step(1);
			n++;
		end while (rdySeen !== 1'b1 && n < 50);
	endtask
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
			output logic [31:0] r);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= {22'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		waitReady(n);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		waitReady(n);
		r = rdSeen;
		check({31'h0, hresp}, 32'h0);
		if (n >= 50) fail_count++;
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		logic [31:0] r;
		bus(1'b0, a, 8'h00, r);
		check(r, {24'h0, e});
	endtask

	// Reference counter: one loop pass per tick or per counted fall
	task automatic model(input int t, md, en0, en1, k, inout int lo, hi, st);
		for (int i = 0; i < k; i++) begin
			if (md == 3 && t == 0) begin
				lo = (lo + en0) % 256;
				if (en0 && lo == 0) st |= 1;
				hi = (hi + en1) % 256;
				if (en1 && hi == 0) st |= 2;
			end else if (en0 && md == 0) begin
				lo = (lo & 224) | ((lo + 1) & 31);
				if ((lo & 31) == 0) hi = (hi + 1) % 256;
				if ((lo & 31) == 0 && hi == 0) st |= 1 << t;
			end else if (en0 && md < 3) begin
				lo = lo + 1;
				if (lo == 256 && (md == 2 || hi == 255)) st |= 1 << t;
				if (lo == 256 && md != 2) hi = (hi + 1) % 256;
				if (lo == 256) lo = (md == 2) ? hi : 0;
			end
		end
	endtask

	task automatic run(input int t, md, src, gate, gpin, lo, hi, k, extra, mask);
		int st, start;
		st = 0;
		if (t == 0) u_src0.setGate(1'(gpin));
		else u_src1.setGate(1'(gpin));
		wr(ad(timer_pkg::IDX_MODE), 8'((gate * 8 + src * 4 + md) << (4 * t)));
		wr(ad(timer_pkg::IDX_LOW0 + t), 8'(lo));
		wr(ad(timer_pkg::IDX_HIGH0 + t), 8'(hi));
		wr(ad(timer_pkg::IDX_MASK), 8'(mask));
		step(8);
		start = cyc;
		wr(ad(timer_pkg::IDX_CONTROL), 8'((1 << (timer_pkg::TR0_BIT + 2 * t)) | extra));
		if (src && t == 0) u_src0.pulses(k, MC);
		if (src && t == 1) u_src1.pulses(k, MC);
		if (src) step(6 * MC);
		while (!src && cyc < start + MC * k) step(1);
		wr(ad(timer_pkg::IDX_CONTROL), 8'h00);
		model(t, md, gate == 0 || gpin != 0, (extra >> 6) & 1, k, lo, hi, st);
		rd(ad(timer_pkg::IDX_LOW0 + t), 8'(lo));
		rd(ad(timer_pkg::IDX_HIGH0 + t), 8'(hi));
		check({31'h0, irq}, 32'((st & mask) != 0));
		rd(ad(timer_pkg::IDX_STATUS), 8'(st));
		step(1);
		check({31'h0, irq}, 32'h0);
		rd(ad(timer_pkg::IDX_STATUS), 8'h00);
	endtask

	task automatic final_report;
		$display("mismatches %0d, comparisons %0d", fail_count, checks);
		if (fail_count == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		final_report();
	end

	initial begin
		void'($urandom(83));
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		step(1);
		rd(ad(timer_pkg::IDX_CONTROL), timer_pkg::CONTROL_RESET);
		rd(ad(timer_pkg::IDX_MODE), timer_pkg::MODE_RESET);
		rd(ad(8'hff), 8'h00);
		repeat (4) begin
			v = 8'($urandom);
			wr(ad(timer_pkg::IDX_MODE), v);
			rd(ad(timer_pkg::IDX_MODE), v);
		end
		// Software may set a flag; interrupt vectoring clears it
		for (int t = 0; t < 2; t++) begin
			wr(ad(timer_pkg::IDX_CONTROL), 8'(1 << (timer_pkg::TF0_BIT + 2 * t)));
			rd(ad(timer_pkg::IDX_CONTROL), 8'(1 << (timer_pkg::TF0_BIT + 2 * t)));
			intAck <= 2'(1 << t);
			step(1);
			intAck <= 2'h0;
			step(1);
			rd(ad(timer_pkg::IDX_CONTROL), 8'h00);
		end
		run(0, 1, 0, 0, 0, 0, 0, 3 + $urandom_range(20), 0, 3);
		run(1, 1, 0, 0, 0, 8'hf0, 8'hff, 20, 0, 3);
		run(0, 0, 0, 0, 0, 8'hfd, 8'hff, 5, 0, 1);
		run(0, 2, 0, 0, 0, 8'hfd, 8'h80, 6, 0, 0);
		run(0, 3, 0, 0, 0, 8'hfe, 8'hfe, 3, 8'h40, 3);
		run(1, 3, 0, 0, 0, 8'h12, 8'h34, 10, 0, 3);
		run(0, 1, 0, 1, 0, 0, 0, 10, 0, 3);
		run(0, 1, 0, 1, 1, 0, 0, 10, 0, 3);
		run(0, 1, 1, 0, 0, 0, 0, 1 + $urandom_range(7), 0, 3);
		run(1, 2, 1, 0, 0, 8'hfe, 8'h10, 5, 0, 3);
		final_report();
	end
endmodule
`default_nettype wire
